// ---- atsc_control.sv ----
/*
 * converter control and touch panel routing: the converter_control,
 * touch_mode_select and two result registers, the start/done sequence and
 * the panel pin routing decode.
 * assumes a byte register port with one-cycle write strobe and a converter
 * core on core_clk that pulses convDone with its 10-bit result.
 */
// Overview of operation
// - bit 7 enables and powers converter
// - bit 6 starts; cleared when conversion done
// - bit 5 read-only done flag, resets one
// - bit 4 reference regulator on/off independently
// - codes 0-5 low inputs, 2.25V scale
// - codes 6-12 rails and inputs, 6.0V scale
// - 1110 touch all, 1111 xy, 1101 undefined
// - mode 0 drives x, mode 1 drives y
// - touch mode low three bits, default 111
// - low result register holds bits 7..0
// - lockout reloads control register defaults
// - high result register holds bits 9..8
module atsc_control
    import atsc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // undervoltage lockout, from analog comparator
    input wire logic undervoltageLockout,
    // register port
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // converter core
    output atsc_core_s coreCtrl,
    output logic convStart,
    input wire logic convDone,
    input wire logic [RESULT_W-1:0] convResult,
    // panel routing
    output atsc_panel_s panelRoute,
    output logic touchOwnsAdc,
    output logic touchXyOnly,
    output logic touchIrqEnable
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } atsc_state_e;

    atsc_state_e state_r;
    logic enable_r;
    logic vref_r;
    logic done_r;
    logic [CC_CHAN_W-1:0] chan_r;
    logic [TM_W-1:0] touchMode_r;
    logic [RESULT_W-1:0] result_r;
    logic uvloMeta_r;
    logic uvloSync_r;
    logic ctrlWrite;
    logic startReq;
    logic touchModeWrite;
    logic abortReq;
    logic busy;

    // channel decodes shared by the core request and the touch outputs
    function automatic logic high_scale(input logic [CC_CHAN_W-1:0] ch);
        return (ch > CH_LAST_LOW_SCALE) && (ch <= CH_LAST_HIGH_SCALE);
    endfunction

    function automatic logic touch_channel(input logic [CC_CHAN_W-1:0] ch);
        return (ch == CH_TOUCH_ALL) || (ch == CH_TOUCH_XY);
    endfunction

    // lockout is an analog level, so synchronise before use
    // only the second flop is read, so a metastable first stage never leaks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uvloMeta_r <= 1'b0;
            uvloSync_r <= 1'b0;
        end else begin
            uvloMeta_r <= undervoltageLockout;
            uvloSync_r <= uvloMeta_r;
        end
    end

    assign ctrlWrite = regWrite && (regAddr == OFF_CONV_CTRL);
    // a start written with the enable bit clear is dropped
    assign startReq = ctrlWrite && regWrData[CC_START_BIT] && regWrData[CC_ENABLE_BIT];
    assign touchModeWrite = regWrite && (regAddr == OFF_TOUCH_MODE);
    assign busy = (state_r == ST_BUSY);
    // clearing enable mid-conversion drops it; the core's late answer is ignored
    assign abortReq = ctrlWrite && !regWrData[CC_ENABLE_BIT];

    // control fields
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= CC_ENABLE_RST;
            vref_r <= CC_VREF_RST;
            chan_r <= CC_CHAN_RST;
        end else if (uvloSync_r) begin
            enable_r <= CC_ENABLE_RST;
            vref_r <= CC_VREF_RST;
            chan_r <= CC_CHAN_RST;
        end else if (ctrlWrite) begin
            enable_r <= regWrData[CC_ENABLE_BIT];
            vref_r <= regWrData[CC_VREF_BIT];
            chan_r <= regWrData[CC_CHAN_LSB +: CC_CHAN_W];
        end
    end

    // touch mode, also reloaded on lockout
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            touchMode_r <= TM_RST;
        end else if (uvloSync_r) begin
            touchMode_r <= TM_RST;
        end else if (touchModeWrite) begin
            touchMode_r <= regWrData[TM_W-1:0];
        end
    end

    // conversion sequence
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else if (uvloSync_r) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (startReq) begin
                        state_r <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    // a second start while busy is refused: no pulse, no restart
                    if (abortReq) begin
                        state_r <= ST_IDLE;
                    end else if (convDone) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // done flag: cleared by an accepted start, set by an answer while busy unless that cycle's write clears enable, or by reset and lockout
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= CC_DONE_RST;
        end else if (uvloSync_r) begin
            done_r <= CC_DONE_RST;
        end else if (convStart) begin
            done_r <= 1'b0;
        end else if (busy && !abortReq && convDone) begin
            done_r <= 1'b1;
        end
    end

    // result captured in the same edge done rises, so never stale
    // no lockout reload: the last conversion stays readable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= '0;
        end else if (busy && convDone) begin
            result_r <= convResult;
        end
    end

    // register read mux
    always_comb begin
        // reserved bits and unmapped offsets read zero
        regRdData = 8'h00;
        unique case (regAddr)
            OFF_CONV_CTRL: begin
                regRdData[CC_ENABLE_BIT] = enable_r;
                regRdData[CC_START_BIT] = busy;
                regRdData[CC_DONE_BIT] = done_r;
                regRdData[CC_VREF_BIT] = vref_r;
                regRdData[CC_CHAN_LSB +: CC_CHAN_W] = chan_r;
            end
            OFF_TOUCH_MODE: regRdData[TM_W-1:0] = touchMode_r;
            OFF_RES_LOW: regRdData = result_r[7:0];
            OFF_RES_HIGH: regRdData[1:0] = result_r[RESULT_W-1:8];
            default: regRdData = 8'h00;
        endcase
    end

    // converter core control
    always_comb begin
        coreCtrl.powerOn = enable_r;
        coreCtrl.vrefOn = vref_r;
        coreCtrl.channel = chan_r;
        // 6.0V scale for 0110..1100, else 2.25V
        coreCtrl.highScale = high_scale(chan_r);
    end

    // combinational, so the core starts in the cycle of the write
    assign convStart = (state_r == ST_IDLE) && startReq;
    // touch channels; 1101 selects nothing
    assign touchOwnsAdc = touch_channel(chan_r);
    assign touchXyOnly = (chan_r == CH_TOUCH_XY);
    assign touchIrqEnable = (touchMode_r != TM_OPEN);

    // panel pin routing
    // no default: all eight modes have a defined routing
    always_comb begin
        unique case (touchMode_r)
            TM_XPOS: panelRoute = '{PIN_REF, PIN_GND, PIN_ADC, PIN_OPEN};
            TM_YPOS: panelRoute = '{PIN_ADC, PIN_OPEN, PIN_REF, PIN_GND};
            TM_PRESSURE: panelRoute = '{PIN_REF, PIN_REF, PIN_GND, PIN_GND};
            TM_PLATE_X: panelRoute = '{PIN_REF, PIN_GND, PIN_OPEN, PIN_OPEN};
            TM_PLATE_Y: panelRoute = '{PIN_OPEN, PIN_OPEN, PIN_REF, PIN_GND};
            TM_STANDBY: panelRoute = '{PIN_BIAS, PIN_BIAS, PIN_GND, PIN_GND};
            TM_ALL_ADC: panelRoute = '{PIN_ADC, PIN_ADC, PIN_ADC, PIN_ADC};
            TM_OPEN: panelRoute = '{PIN_OPEN, PIN_OPEN, PIN_OPEN, PIN_OPEN};
        endcase
    end
endmodule // atsc_control

// ---- atsc_control_asserts.sv ----
/* port assertions for the converter control block.
   assumes one clock domain, core_clk, with rst_n async active low. */
module atsc_control_asserts
    import atsc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // lockout and register port
    input wire logic undervoltageLockout,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // converter and panel
    input wire atsc_core_s coreCtrl,
    input wire logic convStart,
    input wire logic convDone,
    input wire atsc_panel_s panelRoute,
    input wire logic touchIrqEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // control state is only visible while it is addressed
    wire logic ctl = (regAddr == OFF_CONV_CTRL);
    property p_go; regWrite && ctl && regWrData[7:6] == 2'b11 && !regRdData[6] |-> convStart;
    endproperty
    a_go: assert property (p_go) else $error("start write gave no pulse");
    property p_off; convStart |-> regWrite && ctl && regWrData[7:6] == 2'b11; endproperty
    a_off: assert property (p_off) else $error("pulse without enabled start");
    property p_busy; convStart ##1 ctl |-> regRdData[6:5] == 2'b10; endproperty
    a_busy: assert property (p_busy) else $error("busy flags wrong");
    property p_end; convDone && ctl && regRdData[6] ##1 ctl |-> regRdData[6:5] == 2'b01;
    endproperty
    a_end: assert property (p_end) else $error("done flags wrong");
    property p_hi; regAddr == OFF_RES_HIGH |-> regRdData[7:2] == 6'h00; endproperty
    a_hi: assert property (p_hi) else $error("high result upper bits set");
    property p_tm; regAddr == OFF_TOUCH_MODE |->
        regRdData[7:3] == 5'h00 && touchIrqEnable == (regRdData[2:0] != TM_OPEN); endproperty
    a_tm: assert property (p_tm) else $error("touch mode read wrong");
    property p_xpos; regAddr == OFF_TOUCH_MODE && regRdData[2:0] == TM_XPOS |->
        panelRoute == {PIN_REF, PIN_GND, PIN_ADC, PIN_OPEN}; endproperty
    a_xpos: assert property (p_xpos) else $error("x route wrong");
    property p_core; ctl && regRdData[3:0] != CH_UNDEFINED |-> coreCtrl.powerOn == regRdData[7]
        && coreCtrl.vrefOn == regRdData[4] && coreCtrl.channel == regRdData[3:0]
        && coreCtrl.highScale == (regRdData[3:0] inside {[4'h6:4'hC]}); endproperty
    a_core: assert property (p_core) else $error("core request wrong");
    property p_undervoltage_lockout; undervoltageLockout [*4] ##0 ctl |-> regRdData == 8'h20; endproperty
    a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("lockout kept control");
endmodule // atsc_control_asserts

// ---- atsc_core_model.sv ----
/* behavioural converter core: answers a start after a set latency.
   assumes the bench sets latency and the sample value before each start. */
module atsc_core_model
    import atsc_pkg::*;
(
    // clock
    input wire logic core_clk,
    // request and answer
    input wire logic convStart,
    input wire logic [7:0] latency,
    input wire logic [RESULT_W-1:0] sample,
    output logic convDone,
    output logic [RESULT_W-1:0] convResult
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial convDone = 1'b0;
    initial convResult = '0;
    always @(posedge core_clk) begin
        convDone <= (cnt == 1);
        // outside the done pulse the bus toggles, never a held value
        convResult <= (cnt == 1) ? sample : ~convResult;
        cnt <= convStart ? int'(latency) : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule // atsc_core_model

// ---- atsc_pkg.sv ----
/*
 * package for the converter and touch panel control block: register offsets,
 * field positions, reset values, channel and touch mode codes, pad drive types.
 * assumes a byte-wide register port decoded elsewhere by the serial interface.
 */
package atsc_pkg;
    // register offsets
    localparam logic [7:0] OFF_CONV_CTRL = 8'h07;
    localparam logic [7:0] OFF_TOUCH_MODE = 8'h08;
    localparam logic [7:0] OFF_RES_LOW = 8'h09;
    localparam logic [7:0] OFF_RES_HIGH = 8'h0A;
    // converter_control fields
    localparam int CC_ENABLE_BIT = 7;
    localparam int CC_START_BIT = 6;
    localparam int CC_DONE_BIT = 5;
    localparam int CC_VREF_BIT = 4;
    localparam int CC_CHAN_LSB = 0;
    localparam int CC_CHAN_W = 4;
    localparam int TM_W = 3;
    localparam int RESULT_W = 10;
    // reset values
    localparam logic CC_ENABLE_RST = 1'b0;
    localparam logic CC_VREF_RST = 1'b0;
    localparam logic CC_DONE_RST = 1'b1;
    localparam logic [3:0] CC_CHAN_RST = 4'h0;
    localparam logic [2:0] TM_RST = 3'h7;
    // channel codes
    localparam logic [3:0] CH_LAST_LOW_SCALE = 4'h5;
    localparam logic [3:0] CH_LAST_HIGH_SCALE = 4'hC;
    localparam logic [3:0] CH_UNDEFINED = 4'hD;
    localparam logic [3:0] CH_TOUCH_ALL = 4'hE;
    localparam logic [3:0] CH_TOUCH_XY = 4'hF;
    // touch modes
    localparam logic [2:0] TM_XPOS = 3'h0;
    localparam logic [2:0] TM_YPOS = 3'h1;
    localparam logic [2:0] TM_PRESSURE = 3'h2;
    localparam logic [2:0] TM_PLATE_X = 3'h3;
    localparam logic [2:0] TM_PLATE_Y = 3'h4;
    localparam logic [2:0] TM_STANDBY = 3'h5;
    localparam logic [2:0] TM_ALL_ADC = 3'h6;
    localparam logic [2:0] TM_OPEN = 3'h7;

    // what one panel pin is tied to
    typedef enum logic [2:0] {
        PIN_OPEN = 3'h0,
        PIN_REF = 3'h1,
        PIN_GND = 3'h2,
        PIN_ADC = 3'h3,
        PIN_BIAS = 3'h4
    } atsc_pin_e;

    typedef struct packed {
        atsc_pin_e xFirst;
        atsc_pin_e xSecond;
        atsc_pin_e yFirst;
        atsc_pin_e ySecond;
    } atsc_panel_s;

    // request to the analog converter core
    typedef struct packed {
        logic powerOn;
        logic vrefOn;
        logic highScale;
        logic [3:0] channel;
    } atsc_core_s;
endpackage

// ---- test_adc_touch_screen_control.sv ----
/* self-checking bench for the converter control block.
   assumes atsc_pkg, atsc_control, the core model and the checker compile first. */
module test_adc_touch_screen_control
    import atsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic undervoltageLockout = 1'b0;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    atsc_core_s coreCtrl;
    atsc_panel_s panelRoute;
    logic convStart, convDone, touchOwnsAdc, touchXyOnly, touchIrqEnable, started;
    logic [RESULT_W-1:0] convResult;
    logic [RESULT_W-1:0] sample = '0;
    logic [7:0] latency = 8'h01;
    logic [31:0] seed = 32'h4396_fed9;
    int err_count = 0;
    int num_checks = 0;
    atsc_control dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .undervoltageLockout(undervoltageLockout),
        .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .coreCtrl(coreCtrl), .convStart(convStart), .convDone(convDone),
        .convResult(convResult), .panelRoute(panelRoute), .touchOwnsAdc(touchOwnsAdc),
        .touchXyOnly(touchXyOnly), .touchIrqEnable(touchIrqEnable)
    );
    atsc_core_model core_u (
        .core_clk(core_clk), .convStart(convStart), .latency(latency), .sample(sample),
        .convDone(convDone), .convResult(convResult)
    );
    initial forever #4 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // both touch codes hand over the converter; only 1111 limits it to x and y
    function automatic logic [11:0] touch_exp(input logic [3:0] c);
        return {10'h000, c == 4'hF, c >= 4'hE};
    endfunction
    function automatic logic [11:0] route_exp(input int m);
        case (m)
            0: return {PIN_REF, PIN_GND, PIN_ADC, PIN_OPEN};
            1: return {PIN_ADC, PIN_OPEN, PIN_REF, PIN_GND};
            2: return {PIN_REF, PIN_REF, PIN_GND, PIN_GND};
            3: return {PIN_REF, PIN_GND, PIN_OPEN, PIN_OPEN};
            4: return {PIN_OPEN, PIN_OPEN, PIN_REF, PIN_GND};
            5: return {PIN_BIAS, PIN_BIAS, PIN_GND, PIN_GND};
            6: return {PIN_ADC, PIN_ADC, PIN_ADC, PIN_ADC};
            default: return {PIN_OPEN, PIN_OPEN, PIN_OPEN, PIN_OPEN};
        endcase
    endfunction
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(negedge core_clk);
        started = convStart;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input string n, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        @(negedge core_clk);
        chk(n, 12'(e), 12'(regRdData));
    endtask
    task automatic close_out();
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100us;
        err_count++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(OFF_CONV_CTRL, "ctrl reset", 8'h20);
        rd(OFF_TOUCH_MODE, "mode reset", 8'h07);
        for (int m = 0; m < 8; m++) begin
            wr(OFF_TOUCH_MODE, 8'hF8 | 8'(m));
            rd(OFF_TOUCH_MODE, "mode", 8'(m));
            chk("irq enable", 12'(m != 7), 12'(touchIrqEnable));
            chk("route", route_exp(m), panelRoute);
        end
        for (int c = 0; c < 16; c++) begin
            seed = lfsr(seed);
            wr(OFF_CONV_CTRL, {seed[0], 2'b00, seed[1], 4'(c)});
            rd(OFF_CONV_CTRL, "ctrl", {seed[0], 2'b01, seed[1], 4'(c)});
            chk("touch", touch_exp(4'(c)), 12'({touchXyOnly, touchOwnsAdc}));
            chk("core", {5'h00, seed[0], seed[1], (c >= 6 && c <= 12), 4'(c)}, 12'(coreCtrl));
        end
        wr(OFF_CONV_CTRL, 8'h4E);
        chk("no pulse", 12'h000, 12'(started));
        rd(OFF_CONV_CTRL, "ignored start", 8'h2E);
        wr(OFF_TOUCH_MODE, {5'h00, TM_XPOS});
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            sample <= (k == 0) ? 10'h3FF : seed[9:0];
            latency <= (k == 1) ? 8'h01 : 8'(seed[15:10]) + 8'h02;
            wr(OFF_CONV_CTRL, 8'hCE);
            chk("start pulse", 12'h001, 12'(started));
            rd(OFF_CONV_CTRL, "busy", 8'hCE);
            for (int t = 0; t < 200 && regRdData[5] !== 1'b1; t++) @(negedge core_clk);
            rd(OFF_CONV_CTRL, "done", 8'hAE);
            rd(OFF_RES_LOW, "result low", sample[7:0]);
            rd(OFF_RES_HIGH, "result high", {6'h00, sample[9:8]});
        end
        // lockout lands on a running conversion with the reference on
        wr(OFF_CONV_CTRL, 8'hDE);
        chk("lockout start", 12'h001, 12'(started));
        @(posedge core_clk);
        undervoltageLockout <= 1'b1;
        regAddr <= OFF_CONV_CTRL;
        repeat (5) @(posedge core_clk);
        undervoltageLockout <= 1'b0;
        rd(OFF_CONV_CTRL, "lockout ctrl", 8'h20);
        rd(OFF_TOUCH_MODE, "lockout mode", 8'h07);
        rd(OFF_RES_LOW, "kept result", sample[7:0]);
        rd(8'h0B, "unmapped", 8'h00);
        close_out();
    end
endmodule // test_adc_touch_screen_control
bind atsc_control atsc_control_asserts chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .undervoltageLockout(undervoltageLockout),
    .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .coreCtrl(coreCtrl), .convStart(convStart), .convDone(convDone),
    .panelRoute(panelRoute), .touchIrqEnable(touchIrqEnable)
);
